// file: cif_cfg.svh
`ifndef CIF_CFG_SVH
`define CIF_CFG_SVH

// Register byte offsets
`define CIF_OPER_OFS      8'h00
`define CIF_ENABLE_OFS    8'h04
`define CIF_FLAGS_OFS     8'h08
`define CIF_RXMODE_OFS    8'h0c
`define CIF_LIVE_OFS      8'h10

// Flag bit positions, then the receive-mode suppress bit
`define CIF_SEL_BIT       7
`define CIF_TX_BIT        6
`define CIF_RX_BIT        5
`define CIF_CMDEND_BIT    4
`define CIF_UPPER_BIT     3
`define CIF_LOWER_BIT     2
`define CIF_FAULT_BIT     1
`define CIF_TIMER_BIT     0
`define CIF_SUPPRESS_BIT  0

// Reset values and the default known-code mask
`define CIF_FLAGS_RST     7'h14
`define CIF_ENABLE_RST    7'h00
`define CIF_RXMODE_RST    1'h0
`define CIF_IDLE_CODE     4'h0
`define CIF_KNOWN_MASK    16'h00ff
`endif

// file: cif_pkg.sv
package cif_pkg;
	// Command tracker
	typedef enum logic [0:0] {
		CIF_IDLE = 1'b0,
		CIF_BUSY = 1'b1
	} cif_cmd_state_t;
endpackage

// file: cif_communication_irq_flags.sv
`timescale 1ns/1ps
`include "cif_cfg.svh"
module cif_communication_irq_flags #(
	parameter logic [15:0] KNOWN_CODES = `CIF_KNOWN_MASK
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        tx_last_bit_sent,
	input  wire logic        rx_stream_end,
	input  wire logic        fifo_has_data,
	input  wire logic        upper_level_live_status,
	input  wire logic        lower_level_live_status,
	input  wire logic [7:0]  fault_register,
	input  wire logic        timer_expired,
	input  wire logic        command_done,
	output logic      [3:0]  operation_code,
	output logic             command_start,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////
	// Decode helpers

	// One decoder for read and write paths
	function automatic logic [2:0] reg_index(input logic [7:0] a);
		case (a)
			`CIF_OPER_OFS:   reg_index = 3'h1;
			`CIF_ENABLE_OFS: reg_index = 3'h2;
			`CIF_FLAGS_OFS:  reg_index = 3'h3;
			`CIF_RXMODE_OFS: reg_index = 3'h4;
			`CIF_LIVE_OFS:   reg_index = 3'h5;
			default:         reg_index = 3'h0;
		endcase
	endfunction

	function automatic logic code_known(input logic [3:0] c);
		code_known = KNOWN_CODES[c];
	endfunction

	// State, one register per concern
	logic [6:0]              flags_reg;
	logic [6:0]              enable_reg;
	logic                    suppress_reg;
	logic [3:0]              opcode_reg;
	cif_pkg::cif_cmd_state_t cmd_state_reg;
	logic                    start_reg;
	logic                    upper_prev_reg;
	logic                    lower_prev_reg;
	logic [7:0]              fault_prev_reg;
	logic [31:0]             rdata_reg;

	// Combinational helpers, no state
	logic [6:0]              flags_next;
	logic [6:0]              events;
	logic [2:0]              idx;
	logic                    wr_en;
	logic                    setup;
	logic                    unknown_start;
	logic                    cmd_end_event;

	////////////////////////////////////////////////////////////////////
	// APB slave

	// Zero wait states; the access phase completes at once
	assign idx     = reg_index(paddr);
	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pwrite;
	assign pready  = 1'b1;
	// Unmapped offsets answer with an error; their writes are dropped
	assign pslverr = psel && penable && (idx == 3'h0);
	assign prdata  = rdata_reg;

	// Read data caught in the setup cycle, held through access
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_reg <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			case (idx)
				3'h1:    rdata_reg <= {28'h0000000, opcode_reg};
				3'h2:    rdata_reg <= {25'h0000000, enable_reg};
				// Select bit is write only, reads zero
				3'h3:    rdata_reg <= {25'h0000000, flags_reg};
				3'h4:    rdata_reg <= {31'h00000000, suppress_reg};
				3'h5:    rdata_reg <= {27'h0000000, irq, cmd_state_reg == cif_pkg::CIF_BUSY,
					fifo_has_data, upper_level_live_status, lower_level_live_status};
				default: rdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Configuration registers

	// Enable mask and receive mode
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			enable_reg   <= `CIF_ENABLE_RST;
			suppress_reg <= `CIF_RXMODE_RST;
		end else if (wr_en && idx == 3'h2) begin
			enable_reg <= pwdata[6:0];
		end else if (wr_en && idx == 3'h4) begin
			suppress_reg <= pwdata[`CIF_SUPPRESS_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Operation code and command tracking

	// Unknown codes never run; they fall straight back to idle
	assign unknown_start = wr_en && idx == 3'h1 && !code_known(pwdata[3:0]);
	assign cmd_end_event = (command_done && cmd_state_reg == cif_pkg::CIF_BUSY)
		|| unknown_start;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			opcode_reg    <= `CIF_IDLE_CODE;
			cmd_state_reg <= cif_pkg::CIF_IDLE;
			start_reg     <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			if (wr_en && idx == 3'h1) begin
				case (cmd_state_reg)
					cif_pkg::CIF_IDLE, cif_pkg::CIF_BUSY: begin
						if (!code_known(pwdata[3:0]) || pwdata[3:0] == `CIF_IDLE_CODE) begin
							// Software idle abort gives no flag
							opcode_reg    <= `CIF_IDLE_CODE;
							cmd_state_reg <= cif_pkg::CIF_IDLE;
						end else begin
							opcode_reg    <= pwdata[3:0];
							cmd_state_reg <= cif_pkg::CIF_BUSY;
							start_reg     <= 1'b1;
						end
					end
					default: cmd_state_reg <= cif_pkg::CIF_IDLE;
				endcase
			end else if (command_done && cmd_state_reg == cif_pkg::CIF_BUSY) begin
				opcode_reg    <= `CIF_IDLE_CODE;
				cmd_state_reg <= cif_pkg::CIF_IDLE;
			end
		end
	end

	assign operation_code = opcode_reg;
	assign command_start  = start_reg;

	////////////////////////////////////////////////////////////////////
	// Edge capture for level sources

	// Live levels are remembered so only their rise counts
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			upper_prev_reg <= 1'b0;
			lower_prev_reg <= 1'b0;
			fault_prev_reg <= 8'h00;
		end else begin
			upper_prev_reg <= upper_level_live_status;
			lower_prev_reg <= lower_level_live_status;
			fault_prev_reg <= fault_register;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Request flags

	// Hardware events, one per flag bit
	always_comb begin
		events                  = 7'h00;
		events[`CIF_TX_BIT]     = tx_last_bit_sent;
		events[`CIF_RX_BIT]     = rx_stream_end && (!suppress_reg || fifo_has_data);
		events[`CIF_CMDEND_BIT] = cmd_end_event;
		events[`CIF_UPPER_BIT]  = upper_level_live_status && !upper_prev_reg;
		events[`CIF_LOWER_BIT]  = lower_level_live_status && !lower_prev_reg;
		events[`CIF_FAULT_BIT]  = |(fault_register & ~fault_prev_reg);
		events[`CIF_TIMER_BIT]  = timer_expired;
	end

	// Select-bit write, then events OR in so a set beats a clear
	always_comb begin
		flags_next = flags_reg;
		if (wr_en && idx == 3'h3) begin
			if (pwdata[`CIF_SEL_BIT]) begin
				flags_next = flags_reg | pwdata[6:0];
			end else begin
				flags_next = flags_reg & ~pwdata[6:0];
			end
		end
		flags_next = flags_next | events;
	end

	// Flag store; reset marks command end and lower alert
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flags_reg <= `CIF_FLAGS_RST;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// Level interrupt, only enabled flags pass
	assign irq = |(flags_reg & enable_reg);

	////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// Only software writes may drop a flag
	flag_sticky_a: assert property (
		(!(wr_en && idx == 3'h3)) |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
		else $error("flag dropped without software clear");

	// Clear write removes marked flags absent events
	sel_clear_a: assert property (
		(wr_en && idx == 3'h3 && !pwdata[7] && events == 7'h00)
		|=> ((flags_reg & $past(pwdata[6:0])) == 7'h00))
		else $error("select clear failed");

	sel_set_a: assert property (
		(wr_en && idx == 3'h3 && pwdata[7])
		|=> ((flags_reg & $past(pwdata[6:0])) == $past(pwdata[6:0])))
		else $error("select set failed");

	tx_done_a: assert property (
		tx_last_bit_sent |=> flags_reg[`CIF_TX_BIT])
		else $error("transmit done not flagged");

	rx_gate_a: assert property (
		(rx_stream_end && suppress_reg && !fifo_has_data && !flags_reg[`CIF_RX_BIT]
		&& !(wr_en && idx == 3'h3)) |=> !flags_reg[`CIF_RX_BIT])
		else $error("empty receive flagged while suppressed");

	rx_done_a: assert property (
		(rx_stream_end && !suppress_reg) |=> flags_reg[`CIF_RX_BIT])
		else $error("receive done not flagged");

	cmd_end_a: assert property (
		(command_done && cmd_state_reg == cif_pkg::CIF_BUSY && !wr_en)
		|=> flags_reg[`CIF_CMDEND_BIT] && opcode_reg == `CIF_IDLE_CODE)
		else $error("command end not flagged");

	unknown_code_a: assert property (
		unknown_start |=> opcode_reg == `CIF_IDLE_CODE && flags_reg[`CIF_CMDEND_BIT])
		else $error("unknown command not rejected");

	idle_write_a: assert property (
		(wr_en && idx == 3'h1 && pwdata[3:0] == `CIF_IDLE_CODE && !command_done
		&& !flags_reg[`CIF_CMDEND_BIT]) |=> !flags_reg[`CIF_CMDEND_BIT])
		else $error("software idle set command end");

	upper_hold_a: assert property (
		$rose(upper_level_live_status) |=> flags_reg[`CIF_UPPER_BIT])
		else $error("upper alert not captured");

	lower_hold_a: assert property (
		($rose(lower_level_live_status) ##1 !lower_level_live_status && !(wr_en && idx == 3'h3))
		|=> flags_reg[`CIF_LOWER_BIT])
		else $error("lower alert not held");

	fault_flag_a: assert property (
		(|(fault_register & ~fault_prev_reg)) |=> flags_reg[`CIF_FAULT_BIT])
		else $error("fault not flagged");

	// An empty mask keeps the output quiet whatever is pending
	irq_mask_a: assert property (
		(enable_reg == 7'h00) |-> !irq)
		else $error("interrupt ignores enable");

	// An enabled event reaches the output one cycle later
	irq_event_a: assert property (
		(|(events & enable_reg) && !(wr_en && idx == 3'h2)) |=> irq)
		else $error("enabled event gave no interrupt");

	// Zero bits of a flags write leave their flags alone
	sel_keep_a: assert property (
		(wr_en && idx == 3'h3 && events == 7'h00)
		|=> (flags_reg & ~$past(pwdata[6:0])) == ($past(flags_reg) & ~$past(pwdata[6:0])))
		else $error("unmarked flag changed");

	// Upper alert outlives its live level
	upper_keep_a: assert property (
		($rose(upper_level_live_status) ##1 !upper_level_live_status && !(wr_en && idx == 3'h3))
		|=> flags_reg[`CIF_UPPER_BIT])
		else $error("upper alert not held");

	// Timer expiry latches like any other event
	timer_flag_a: assert property (
		timer_expired |=> flags_reg[`CIF_TIMER_BIT])
		else $error("timer expiry not flagged");

	// A known busy code is stored and started at once
	start_pulse_a: assert property (
		(wr_en && idx == 3'h1 && code_known(pwdata[3:0]) && pwdata[3:0] != `CIF_IDLE_CODE)
		|=> command_start && operation_code == $past(pwdata[3:0]))
		else $error("known command not started");

	// Start strobe only while a command is running
	cmd_busy_a: assert property (
		command_start |-> cmd_state_reg == cif_pkg::CIF_BUSY)
		else $error("start without busy command");

	// The code field never keeps an unknown value
	opcode_known_a: assert property (
		code_known(operation_code))
		else $error("unknown code held in field");

	// Software idle stops a running command at once
	idle_abort_a: assert property (
		(wr_en && idx == 3'h1 && pwdata[3:0] == `CIF_IDLE_CODE)
		|=> operation_code == `CIF_IDLE_CODE && cmd_state_reg == cif_pkg::CIF_IDLE)
		else $error("software idle did not stop command");

	// Mask and receive mode take the written value
	enable_write_a: assert property (
		(wr_en && idx == 3'h2) |=> enable_reg == $past(pwdata[6:0]))
		else $error("enable mask not written");

	mode_write_a: assert property (
		(wr_en && idx == 3'h4) |=> suppress_reg == $past(pwdata[`CIF_SUPPRESS_BIT]))
		else $error("receive mode not written");

	// Reads return the snapshot taken in the setup cycle
	read_flags_a: assert property (
		(setup && !pwrite && idx == 3'h3) |=> prdata == {25'h0000000, $past(flags_reg)})
		else $error("flags read wrong");

	read_live_a: assert property (
		(setup && !pwrite && idx == 3'h5) |=> prdata[2:0] == {$past(fifo_has_data),
		$past(upper_level_live_status), $past(lower_level_live_status)})
		else $error("live status read wrong");

	// Main scenarios worth seeing in simulation
	tx_irq_c:     cover property (tx_last_bit_sent && enable_reg[`CIF_TX_BIT] ##1 irq);
	unknown_c:    cover property (unknown_start);
	clear_race_c: cover property (wr_en && idx == 3'h3 && !pwdata[7] && |events);
	rx_supp_c:    cover property (rx_stream_end && suppress_reg && !fifo_has_data);
	cmd_done_c:   cover property (command_done && cmd_state_reg == cif_pkg::CIF_BUSY);

endmodule

// file: cif_communication_irq_flags_tb_top.sv
`timescale 1ns/1ps
`include "cif_cfg.svh"
module cif_communication_irq_flags_tb_top;
	localparam logic [7:0] FL = `CIF_FLAGS_OFS;
	localparam logic [7:0] EN = `CIF_ENABLE_OFS;
	localparam logic [7:0] OP = `CIF_OPER_OFS;
	localparam logic [31:0] EVM [6] = '{32'h40, 32'h20, 32'h01, 32'h08, 32'h04, 32'h02};
	logic        clk;
	logic        rstn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [6:0]  stim;
	logic        fifo_has_data;
	logic [3:0]  operation_code;
	logic        command_start;
	logic        irq;
	logic [31:0] rd;
	logic        err;
	int          miscompares;
	int          samples_checked;
	int          i;

	cif_communication_irq_flags dut_u (
		.clk                     (clk),
		.rstn                    (rstn),
		.psel                    (psel),
		.penable                 (penable),
		.pwrite                  (pwrite),
		.paddr                   (paddr),
		.pwdata                  (pwdata),
		.prdata                  (prdata),
		.pready                  (pready),
		.pslverr                 (pslverr),
		.tx_last_bit_sent        (stim[0]),
		.rx_stream_end           (stim[1]),
		.fifo_has_data           (fifo_has_data),
		.upper_level_live_status (stim[3]),
		.lower_level_live_status (stim[4]),
		.fault_register          ({5'h00, stim[5], 2'h0}),
		.timer_expired           (stim[2]),
		.command_done            (stim[6]),
		.operation_code          (operation_code),
		.command_start           (command_start),
		.irq                     (irq)
	);

	// Free running 10 MHz clock
	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	// Report and compare
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk1(input string n, input logic e, input logic g);
		chk32(n, {31'h0, e}, {31'h0, g});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// APB master; waits on pready under a bound, never assumes latency
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			miscompares++;
			end_of_test();
		end else begin
			rd      = prdata;
			err     = pslverr;
			psel    <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk32(n, e, rd);
	endtask

	// One cycle high on an event or live level input
	task automatic pulse(input int k);
		@(posedge clk);
		stim[k] <= 1'b1;
		@(posedge clk);
		stim[k] <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		clk = 1'h0;
		rstn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		stim = 7'h00;
		fifo_has_data = 1'h0;
		miscompares = 0;
		samples_checked = 0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rdchk("flags_rst", FL, 32'h14);
		rdchk("enable_rst", EN, 32'h0);
		chk1("irq_rst", 1'b0, irq);
		// Select bit: ones set or clear, zeros leave alone
		apb(1'b1, FL, 32'hc1);
		rdchk("flags_set", FL, 32'h55);
		apb(1'b1, FL, 32'h04);
		rdchk("flags_clr", FL, 32'h51);
		apb(1'b1, FL, 32'h80);
		rdchk("flags_keep", FL, 32'h51);
		apb(1'b1, FL, 32'h7f);
		// Each event but command end sets its own bit, reading does not clear it
		for (i = 0; i < 6; i++) begin
			pulse(i);
			rdchk("event_flag", FL, EVM[i]);
			rdchk("flag_sticky", FL, EVM[i]);
			apb(1'b1, FL, 32'h7f);
		end
		// Empty frame suppressed until FIFO holds data
		apb(1'b1, `CIF_RXMODE_OFS, 32'h1);
		pulse(1);
		rdchk("rx_empty", FL, 32'h0);
		fifo_has_data <= 1'b1;
		pulse(1);
		rdchk("rx_data", FL, 32'h20);
		apb(1'b1, FL, 32'h7f);
		// Command ends normally
		apb(1'b1, OP, 32'h1);
		#1 chk1("cmd_start", 1'b1, command_start);
		chk32("op_run", 32'h1, {28'h0, operation_code});
		pulse(6);
		#1 chk32("op_end", 32'h0, {28'h0, operation_code});
		rdchk("cmd_end", FL, 32'h10);
		apb(1'b1, FL, 32'h7f);
		// Unknown code ends a running command and falls back to idle
		apb(1'b1, OP, 32'h2);
		apb(1'b1, OP, 32'h8);
		#1 chk32("op_unknown", 32'h0, {28'h0, operation_code});
		rdchk("unknown_end", FL, 32'h10);
		apb(1'b1, FL, 32'h7f);
		// Software idle aborts without a flag; late done ignored
		apb(1'b1, OP, 32'h2);
		apb(1'b1, OP, 32'h0);
		pulse(6);
		rdchk("idle_write", FL, 32'h0);
		// Interrupt output follows flags and enables
		apb(1'b1, EN, 32'h40);
		#1 chk1("irq_none", 1'b0, irq);
		pulse(0);
		#1 chk1("irq_on", 1'b1, irq);
		apb(1'b1, EN, 32'h0);
		#1 chk1("irq_masked", 1'b0, irq);
		apb(1'b1, EN, 32'h40);
		apb(1'b1, FL, 32'h40);
		#1 chk1("irq_cleared", 1'b0, irq);
		// Event at the clearing edge: the set wins
		@(posedge clk);
		stim[0] <= 1'b1;
		apb(1'b1, FL, 32'h40);
		stim[0] <= 1'b0;
		rdchk("set_wins", FL, 32'h40);
		apb(1'b1, FL, 32'h7f);
		// Live status shows a running command and FIFO data
		apb(1'b1, OP, 32'h3);
		rdchk("live_busy", `CIF_LIVE_OFS, 32'h0c);
		apb(1'b1, OP, 32'h0);
		rdchk("rx_mode", `CIF_RXMODE_OFS, 32'h1);
		// Unmapped address refused, flags untouched
		apb(1'b1, 8'h14, 32'hff);
		chk1("wr_err", 1'b1, err);
		apb(1'b0, 8'h14, 32'h0);
		chk32("rd_unmapped", 32'h0, rd);
		chk1("rd_err", 1'b1, err);
		rdchk("flags_after", FL, 32'h0);
		chk1("ok_err", 1'b0, err);
		end_of_test();
	end
endmodule
